// *** hdl/lp_cmd_timing.sv ***
// per-rank low-power command timing with apb timing registers
// assumes dfi clock equals pclk and one request strobe per cycle
//
// Design decision made here: the APB interface to the registers.
`default_nettype none
// Function
// - after max power-down exit, wait the exit count before next rank command
// - max power-down exit field is bits 11:0, values 1 to 4094
// - after power-down entry, hold rank commands for the entry count
// - on power-down exit, delay non-dll commands by the low-byte count
// - on power-down exit, delay dll commands by bits 23:16 count
// - after self-refresh entry, hold rank commands for the entry count
// - after self-refresh exit, delay non-dll commands by the 10-bit count
// - after self-refresh exit, delay dll commands by the bits 26:16 count
// - stop dram clock only after the entry-to-stop count elapses
// - leave the state only after clock-restart count elapses
// - account for command/address latency from bits 11:8
// - drive command and address the programmed clocks after chip select
// - command complete the programmed cycles after chip select
// - drive parity the programmed clocks after chip select
// - after zq short calibration, wait the calibration delay for that rank
// - zq short delay field is bits 9:0, values 2 to 1023
// - timing registers read and write in any state, reserved bits zero
module lp_cmd_timing #(
    parameter int NRANK = lp_timing_pkg::NRANK
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // command request
    input wire logic cmd_valid,
    input wire lp_timing_pkg::cmd_t cmd_req,
    output logic cmd_accept,
    output logic cmd_reject,
    output logic [NRANK-1:0] cmd_done,
    output logic [NRANK-1:0] rank_ready,
    // dfi side
    output logic [NRANK-1:0] dfi_cs_n,
    output logic [lp_timing_pkg::ADDR_W-1:0] dfi_address,
    output logic dfi_address_valid,
    output logic dfi_parity_in,
    output logic [NRANK-1:0] dram_clk_disable
);
    localparam int ST_W = lp_timing_pkg::ST_W;
    localparam int AW = lp_timing_pkg::ADDR_W;
    localparam int DD = lp_timing_pkg::DLY_D;

    // ========================================
    // register file
    logic [lp_timing_pkg::REG_N-1:0][31:0] cfg_q;
    logic [31:0] stat;
    logic [3:0] ri;
    logic hit;
    logic wr_now;

    function automatic logic [ST_W-1:0] fld(input logic [31:0] v, input int lsb, input int w);
        logic [31:0] m;
        m = (32'h1 << w) - 32'h1;
        fld = ST_W'((v >> lsb) & m);
    endfunction

    function automatic logic [ST_W-1:0] dec(input logic [ST_W-1:0] v);
        dec = (v == '0) ? '0 : v - ST_W'(1);
    endfunction

    always_comb begin
        logic [11:0] o;
        o = paddr - lp_timing_pkg::OFS_XMPD;
        ri = o[5:2];
        hit = paddr >= lp_timing_pkg::OFS_XMPD && paddr <= lp_timing_pkg::OFS_STAT
            && paddr[1:0] == 2'b00;
    end

    assign wr_now = ce && psel && penable && pready && pwrite && hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= lp_timing_pkg::RST_VAL;
        end else if (wr_now) begin
            // accepted in every controller state
            cfg_q[ri] <= pwdata & lp_timing_pkg::WMASK[ri];
        end
    end

    // no wait state; answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (ce) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable) begin
                // reserved bits masked to zero
                prdata <= !hit ? 32'h0 : (ri == lp_timing_pkg::I_STAT) ? stat : cfg_q[ri];
            end
        end
    end

    // ========================================
    // field views
    logic [ST_W-1:0] t_xmpd, t_ep, t_xp, t_xpdll, t_esr, t_xsr, t_xsrdll;
    logic [ST_W-1:0] t_esrck, t_ckxsr, t_cmdlat, t_cal, t_parin, t_cmpl, t_zq;
    always_comb begin
        t_xmpd = fld(cfg_q[lp_timing_pkg::I_XMPD], lp_timing_pkg::F_LO, lp_timing_pkg::W_XMPD);
        t_ep = fld(cfg_q[lp_timing_pkg::I_EP], lp_timing_pkg::F_LO, lp_timing_pkg::W_8);
        t_xp = fld(cfg_q[lp_timing_pkg::I_XP], lp_timing_pkg::F_LO, lp_timing_pkg::W_8);
        t_xpdll = fld(cfg_q[lp_timing_pkg::I_XP], lp_timing_pkg::F_HI, lp_timing_pkg::W_8);
        t_esr = fld(cfg_q[lp_timing_pkg::I_ESR], lp_timing_pkg::F_LO, lp_timing_pkg::W_8);
        t_xsr = fld(cfg_q[lp_timing_pkg::I_XSR], lp_timing_pkg::F_LO, lp_timing_pkg::W_XSR);
        t_xsrdll = fld(cfg_q[lp_timing_pkg::I_XSR], lp_timing_pkg::F_HI, lp_timing_pkg::W_XSRDLL);
        t_esrck = fld(cfg_q[lp_timing_pkg::I_ESRCK], lp_timing_pkg::F_LO, lp_timing_pkg::W_CK);
        t_ckxsr = fld(cfg_q[lp_timing_pkg::I_CKXSR], lp_timing_pkg::F_LO, lp_timing_pkg::W_CK);
        t_cmdlat = fld(cfg_q[lp_timing_pkg::I_CMD], lp_timing_pkg::F_LO, lp_timing_pkg::W_4);
        t_cal = fld(cfg_q[lp_timing_pkg::I_CMD], lp_timing_pkg::F_MID, lp_timing_pkg::W_4);
        t_parin = fld(cfg_q[lp_timing_pkg::I_PAR], lp_timing_pkg::F_LO, lp_timing_pkg::W_PAR);
        t_cmpl = fld(cfg_q[lp_timing_pkg::I_PAR], lp_timing_pkg::F_MID, lp_timing_pkg::W_CMPL);
        t_zq = fld(cfg_q[lp_timing_pkg::I_ZQ], lp_timing_pkg::F_LO, lp_timing_pkg::W_ZQ);
    end

    // ========================================
    // per-rank state
    lp_timing_pkg::pstate_t ps_q [NRANK];
    logic [ST_W-1:0] nd_q [NRANK];
    logic [ST_W-1:0] dl_q [NRANK];
    logic [ST_W-1:0] ck_q [NRANK];
    logic [ST_W-1:0] cp_q [NRANK];
    logic [NRANK-1:0] arm_q;
    logic [NRANK-1:0] off_q;

    // request check against the addressed rank only
    function automatic logic legal(input lp_timing_pkg::kind_t k, input lp_timing_pkg::pstate_t s,
                                   input logic nd0, input logic dl0, input logic ck0, input logic off);
        logic act;
        act = s == lp_timing_pkg::PS_ACT;
        case (k)
            lp_timing_pkg::K_NODLL: legal = act && nd0;
            lp_timing_pkg::K_DLL: legal = act && dl0;
            lp_timing_pkg::K_PD_IN, lp_timing_pkg::K_SR_IN, lp_timing_pkg::K_MPD_IN,
            lp_timing_pkg::K_ZQCS: legal = act && nd0 && dl0;
            lp_timing_pkg::K_PD_OUT: legal = s == lp_timing_pkg::PS_PD && nd0 && dl0;
            lp_timing_pkg::K_SR_OUT: legal = s == lp_timing_pkg::PS_SR && !off && ck0 && nd0;
            lp_timing_pkg::K_MPD_OUT: legal = s == lp_timing_pkg::PS_MPD && !off && ck0 && nd0;
            lp_timing_pkg::K_CK_ON: legal = off;
            default: legal = 1'b0;
        endcase
    endfunction

    lp_timing_pkg::kind_t kd;
    logic [lp_timing_pkg::RANK_W-1:0] rk;
    logic take;
    always_comb begin
        kd = cmd_req.kind;
        rk = cmd_req.rank;
        take = 1'b0;
        if (cmd_valid && 32'(rk) < NRANK) begin
            take = legal(kd, ps_q[rk], nd_q[rk] == '0, dl_q[rk] == '0, ck_q[rk] == '0, off_q[rk]);
        end
    end

    // hold values that a taken request loads; ld_nd non-dll, ld_dl dll
    logic [ST_W-1:0] ld_nd, ld_dl;
    logic ld_on;
    always_comb begin
        ld_on = 1'b1;
        ld_nd = '0;
        ld_dl = '0;
        case (kd)
            lp_timing_pkg::K_PD_IN: begin
                ld_nd = t_ep;
                ld_dl = t_ep;
            end
            lp_timing_pkg::K_PD_OUT: begin
                ld_nd = t_xp;
                ld_dl = t_xpdll;
            end
            lp_timing_pkg::K_SR_IN, lp_timing_pkg::K_MPD_IN: begin
                ld_nd = t_esr;
                ld_dl = t_esr;
            end
            lp_timing_pkg::K_SR_OUT: begin
                ld_nd = t_xsr;
                ld_dl = t_xsrdll;
            end
            lp_timing_pkg::K_MPD_OUT: begin
                ld_nd = t_xmpd;
                ld_dl = t_xmpd;
            end
            lp_timing_pkg::K_ZQCS: begin
                ld_nd = t_zq;
                ld_dl = t_zq;
            end
            default: ld_on = 1'b0;
        endcase
    end

    for (genvar r = 0; r < NRANK; r++) begin : g_rank
        logic mine;
        assign mine = take && 32'(rk) == r;

        // hold-off counters; nonzero blocks the matching class
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                nd_q[r] <= '0;
                dl_q[r] <= '0;
            end else if (ce) begin
                if (mine && ld_on) begin
                    nd_q[r] <= dec(ld_nd);
                    dl_q[r] <= dec(ld_dl);
                end else begin
                    nd_q[r] <= dec(nd_q[r]);
                    dl_q[r] <= dec(dl_q[r]);
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ps_q[r] <= lp_timing_pkg::PS_ACT;
            end else if (ce && mine) begin
                case (kd)
                    lp_timing_pkg::K_PD_IN: ps_q[r] <= lp_timing_pkg::PS_PD;
                    lp_timing_pkg::K_SR_IN: ps_q[r] <= lp_timing_pkg::PS_SR;
                    lp_timing_pkg::K_MPD_IN: ps_q[r] <= lp_timing_pkg::PS_MPD;
                    lp_timing_pkg::K_PD_OUT, lp_timing_pkg::K_SR_OUT,
                    lp_timing_pkg::K_MPD_OUT: ps_q[r] <= lp_timing_pkg::PS_ACT;
                    default: ps_q[r] <= ps_q[r];
                endcase
            end
        end

        // dram clock stop after entry, restart before exit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ck_q[r] <= '0;
                arm_q[r] <= 1'b0;
                off_q[r] <= 1'b0;
            end else if (ce) begin
                if (mine && (kd == lp_timing_pkg::K_SR_IN || kd == lp_timing_pkg::K_MPD_IN)) begin
                    ck_q[r] <= dec(t_esrck);
                    arm_q[r] <= 1'b1;
                end else if (mine && kd == lp_timing_pkg::K_CK_ON) begin
                    ck_q[r] <= dec(t_ckxsr);
                    off_q[r] <= 1'b0;
                end else if (arm_q[r] && ck_q[r] == '0) begin
                    off_q[r] <= 1'b1;
                    arm_q[r] <= 1'b0;
                end else begin
                    ck_q[r] <= dec(ck_q[r]);
                end
            end
        end

        // completion timer from chip select
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cp_q[r] <= '0;
                cmd_done[r] <= 1'b0;
            end else if (ce) begin
                cmd_done[r] <= cp_q[r] == ST_W'(1);
                cp_q[r] <= mine ? t_cmpl : dec(cp_q[r]);
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                dfi_cs_n[r] <= 1'b1;
                rank_ready[r] <= 1'b0;
            end else if (ce) begin
                dfi_cs_n[r] <= !mine;
                rank_ready[r] <= ps_q[r] == lp_timing_pkg::PS_ACT && nd_q[r] == '0 && dl_q[r] == '0;
            end
        end
    end

    always_comb begin
        stat = 32'h0;
        for (int r = 0; r < NRANK; r++) begin
            stat[r] = rank_ready[r];
            stat[lp_timing_pkg::S_CLK + r] = off_q[r];
            stat[lp_timing_pkg::S_PST + 2 * r +: 2] = ps_q[r];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_accept <= 1'b0;
            cmd_reject <= 1'b0;
        end else if (ce) begin
            cmd_accept <= take;
            cmd_reject <= cmd_valid && !take;
        end
    end

    // ========================================
    // command, address and parity delay line
    lp_timing_pkg::stage_t line_q [DD];
    lp_timing_pkg::stage_t now_s;
    logic [ST_W-1:0] a_dly;
    assign now_s = '{ok: take, a: cmd_req.addr};
    assign a_dly = t_cmdlat + t_cal;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DD; i++) begin
                line_q[i] <= '0;
            end
        end else if (ce) begin
            line_q[0] <= now_s;
            for (int i = 1; i < DD; i++) begin
                line_q[i] <= line_q[i-1];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dfi_address <= '0;
            dfi_address_valid <= 1'b0;
            dfi_parity_in <= 1'b0;
        end else if (ce) begin
            if (a_dly == '0) begin
                dfi_address <= now_s.a;
                dfi_address_valid <= now_s.ok;
            end else begin
                dfi_address <= line_q[a_dly-1].a;
                dfi_address_valid <= line_q[a_dly-1].ok;
            end
            dfi_parity_in <= (t_parin == '0) ? ^now_s.a : ^line_q[t_parin-1].a;
        end
    end

    assign dram_clk_disable = off_q;

    // ========================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_take0_c9;
        ce && take && rk == '0 && t_cmpl == ST_W'(9);
    endsequence
    sequence s_quiet8;
        (ce && !(take && rk == '0))[*8];
    endsequence

    chk_wait_nodll: assert property (take && kd == lp_timing_pkg::K_NODLL |-> nd_q[rk] == '0)
        else $error("non-dll command issued during hold-off");
    chk_wait_dll: assert property (take && kd == lp_timing_pkg::K_DLL |-> dl_q[rk] == '0)
        else $error("dll command issued during hold-off");
    chk_entry_hold: assert property (ce && take && kd == lp_timing_pkg::K_PD_IN && t_ep > ST_W'(1)
        |=> ##1 !rank_ready[$past(rk, 2)] ##1 !rank_ready[$past(rk, 3)])
        else $error("rank ready too soon after power-down entry");
    chk_done_time: assert property (s_take0_c9 ##1 s_quiet8 |-> ##2 cmd_done[0])
        else $error("completion not at programmed cycle");
    chk_clk_stop: assert property ($rose(off_q[0]) |-> $past(ck_q[0]) == '0 && ps_q[0] != lp_timing_pkg::PS_ACT)
        else $error("dram clock stopped early");
    chk_exit_clock: assert property (take && (kd == lp_timing_pkg::K_SR_OUT || kd == lp_timing_pkg::K_MPD_OUT)
        |-> !off_q[rk] && ck_q[rk] == '0)
        else $error("exit before clock restart delay");
    chk_addr_zero: assert property (ce && take && a_dly == '0 |=> dfi_address_valid && !(&dfi_cs_n))
        else $error("address not with chip select at zero latency");
    chk_apb_ready: assert property (ce && psel && !penable |=> pready)
        else $error("apb access not answered");
    chk_resv_zero: assert property (ce && psel && !penable && paddr == lp_timing_pkg::OFS_XMPD
        |=> prdata[31:12] == 20'h0)
        else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// *** hdl/lp_timing_pkg.sv ***
// constants, register map and carriers of the low-power timing block
// assumes one controller clock equal to the dfi clock
`default_nettype none
package lp_timing_pkg;
    // ========================================
    // sizes
    localparam int NRANK = 4;
    localparam int RANK_W = 2;
    localparam int ADDR_W = 16;
    localparam int ST_W = 12;
    localparam int DLY_D = 32;
    localparam int REG_N = 11;
    // ========================================
    // register offsets and indices
    localparam logic [11:0] OFS_XMPD = 12'h254;
    localparam logic [11:0] OFS_EP = 12'h258;
    localparam logic [11:0] OFS_XP = 12'h25C;
    localparam logic [11:0] OFS_ESR = 12'h260;
    localparam logic [11:0] OFS_XSR = 12'h264;
    localparam logic [11:0] OFS_ESRCK = 12'h268;
    localparam logic [11:0] OFS_CKXSR = 12'h26C;
    localparam logic [11:0] OFS_CMD = 12'h270;
    localparam logic [11:0] OFS_PAR = 12'h274;
    localparam logic [11:0] OFS_ZQ = 12'h278;
    localparam logic [11:0] OFS_STAT = 12'h27C;
    localparam logic [3:0] I_XMPD = 4'h0;
    localparam logic [3:0] I_EP = 4'h1;
    localparam logic [3:0] I_XP = 4'h2;
    localparam logic [3:0] I_ESR = 4'h3;
    localparam logic [3:0] I_XSR = 4'h4;
    localparam logic [3:0] I_ESRCK = 4'h5;
    localparam logic [3:0] I_CKXSR = 4'h6;
    localparam logic [3:0] I_CMD = 4'h7;
    localparam logic [3:0] I_PAR = 4'h8;
    localparam logic [3:0] I_ZQ = 4'h9;
    localparam logic [3:0] I_STAT = 4'hA;
    // element 0 is the register at OFS_XMPD
    localparam logic [REG_N-1:0][31:0] RST_VAL = {
        32'h0, 32'h40, 32'h900, 32'h0, 32'h1, 32'h5,
        32'h05120100, 32'hE, 32'h00060002, 32'h2, 32'h3FF};
    localparam logic [REG_N-1:0][31:0] WMASK = {
        32'h0, 32'h3FF, 32'h3F03, 32'hF0F, 32'h1F, 32'h1F,
        32'h07FF03FF, 32'hFF, 32'h00FF00FF, 32'hFF, 32'hFFF};
    // ========================================
    // field positions
    localparam int F_LO = 0;
    localparam int F_HI = 16;
    localparam int F_MID = 8;
    localparam int W_XMPD = 12;
    localparam int W_8 = 8;
    localparam int W_XSR = 10;
    localparam int W_XSRDLL = 11;
    localparam int W_CK = 5;
    localparam int W_4 = 4;
    localparam int W_PAR = 2;
    localparam int W_CMPL = 6;
    localparam int W_ZQ = 10;
    localparam int S_CLK = 4;
    localparam int S_PST = 16;
    // ========================================
    // types
    typedef enum logic [3:0] {
        K_NODLL = 4'h0, K_DLL = 4'h1, K_PD_IN = 4'h2, K_PD_OUT = 4'h3,
        K_SR_IN = 4'h4, K_SR_OUT = 4'h5, K_MPD_IN = 4'h6, K_MPD_OUT = 4'h7,
        K_ZQCS = 4'h8, K_CK_ON = 4'h9
    } kind_t;
    typedef enum logic [1:0] {
        PS_ACT = 2'b00, PS_PD = 2'b01, PS_SR = 2'b10, PS_MPD = 2'b11
    } pstate_t;
    typedef struct packed {
        kind_t kind;
        logic [RANK_W-1:0] rank;
        logic [ADDR_W-1:0] addr;
    } cmd_t;
    typedef struct packed {
        logic ok;
        logic [ADDR_W-1:0] a;
    } stage_t;
endpackage
`default_nettype wire

// *** tb/dfi_phy_model.sv ***
// dfi phy stand-in: times address and parity after each chip select
// assumes dfi clock equals pclk and one command in flight at a time
`default_nettype none
module dfi_phy_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // dfi command side
    input wire logic [lp_timing_pkg::NRANK-1:0] dfi_cs_n,
    input wire logic [lp_timing_pkg::ADDR_W-1:0] dfi_address,
    input wire logic dfi_address_valid,
    input wire logic dfi_parity_in,
    // measurements
    output logic [7:0] addr_dly,
    output logic [15:0] addr_seen,
    output logic [3:0] par_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    // ==========
    // cycles since the last chip select
    always @(posedge pclk or negedge presetn) begin : watch
        logic [7:0] c;
        if (!presetn) begin
            cnt_q <= 8'hF0;
            addr_dly <= 8'hFF;
            addr_seen <= 16'h0000;
            par_seen <= 4'h0;
        end else begin
            // saturates so long idle spans never alias a fresh select
            c = (&dfi_cs_n) ? ((cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01) : 8'h00;
            cnt_q <= c;
            if (dfi_address_valid) begin
                addr_dly <= c;
                addr_seen <= dfi_address;
            end
            if (c < 8'h04) begin
                par_seen[c[1:0]] <= dfi_parity_in;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/dram_lowpower_cmd_timing_tb.sv ***
// self-checking bench for the low-power command timing block
// assumes dut and phy model share pclk; apb master and command driver here
`default_nettype none
module dram_lowpower_cmd_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // signals
    logic pclk, presetn, psel, penable, pwrite, cmd_valid, pready, pslverr, err;
    logic cmd_accept, cmd_reject, adv, par, ce;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    lp_timing_pkg::cmd_t cmd_req;
    logic [3:0] cmd_done, rank_ready, cs_n, ckdis, pseen;
    logic [15:0] daddr, aseen;
    logic [7:0] adly;
    int n_errors, checked;
    localparam logic [31:0] RST [10] = '{32'h3FF, 32'h2, 32'h00060002, 32'hE, 32'h05120100,
        32'h5, 32'h1, 32'h0, 32'h900, 32'h40};
    localparam logic [31:0] MSK [10] = '{32'hFFF, 32'hFF, 32'h00FF00FF, 32'hFF, 32'h07FF03FF,
        32'h1F, 32'h1F, 32'hF0F, 32'h3F03, 32'h3FF};
    // ==========
    // dut and far side
    lp_cmd_timing u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_req(cmd_req), .cmd_accept(cmd_accept),
        .cmd_reject(cmd_reject), .cmd_done(cmd_done), .rank_ready(rank_ready), .dfi_cs_n(cs_n),
        .dfi_address(daddr), .dfi_address_valid(adv), .dfi_parity_in(par), .dram_clk_disable(ckdis));
    dfi_phy_model u_phy (.pclk(pclk), .presetn(presetn), .dfi_cs_n(cs_n), .dfi_address(daddr),
        .dfi_address_valid(adv), .dfi_parity_in(par), .addr_dly(adly), .addr_seen(aseen),
        .par_seen(pseen));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // ==========
    // shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic one(input lp_timing_pkg::kind_t k, input logic [1:0] r, input logic [15:0] a);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_req <= '{kind: k, rank: r, addr: a};
        @(posedge pclk);
        cmd_valid <= 1'b0;
        #1 chk("accept", 32'h1, 32'(cmd_accept));
    endtask
    // refused one cycle before the hold ends, taken n cycles after the last one
    task automatic gate(input lp_timing_pkg::kind_t k, input logic [1:0] r, input int n);
        repeat (n - 2) @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_req <= '{kind: k, rank: r, addr: 16'h0000};
        @(posedge pclk);
        #1 chk("early reject", 32'h1, 32'(cmd_reject));
        @(posedge pclk);
        cmd_valid <= 1'b0;
        #1 chk("accept", 32'h1, 32'(cmd_accept));
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========
    // scenarios
    task automatic t_regs();
        logic [11:0] a;
        for (int i = 0; i < 10; i++) begin
            a = 12'h254 + 12'(4 * i);
            apb(1'b0, a, 32'h0);
            chk("reset value", RST[i], rd);
            apb(1'b1, a, 32'hFFFFFFFF);
            apb(1'b0, a, 32'h0);
            chk("masked value", MSK[i], rd);
            apb(1'b1, a, RST[i]);
        end
        apb(1'b0, 12'h280, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
    endtask
    task automatic t_pd();
        apb(1'b1, lp_timing_pkg::OFS_EP, 32'h5);
        apb(1'b1, lp_timing_pkg::OFS_XP, 32'h00070003);
        one(lp_timing_pkg::K_PD_IN, 2'd0, 16'h0);
        one(lp_timing_pkg::K_NODLL, 2'd1, 16'h0);
        chk("rank ready", 32'hE, 32'(rank_ready));
        gate(lp_timing_pkg::K_PD_OUT, 2'd0, 3);
        gate(lp_timing_pkg::K_NODLL, 2'd0, 3);
        gate(lp_timing_pkg::K_DLL, 2'd0, 4);
    endtask
    task automatic t_sr();
        apb(1'b1, lp_timing_pkg::OFS_ESR, 32'h4);
        apb(1'b1, lp_timing_pkg::OFS_XSR, 32'h00090003);
        apb(1'b1, lp_timing_pkg::OFS_ESRCK, 32'h3);
        apb(1'b1, lp_timing_pkg::OFS_CKXSR, 32'h3);
        one(lp_timing_pkg::K_SR_IN, 2'd0, 16'h0);
        repeat (2) @(posedge pclk);
        #1 chk("clock still on", 32'h0, 32'(ckdis[0]));
        @(posedge pclk);
        #1 chk("clock stopped", 32'h1, 32'(ckdis[0]));
        one(lp_timing_pkg::K_CK_ON, 2'd0, 16'h0);
        chk("clock restarted", 32'h0, 32'(ckdis[0]));
        gate(lp_timing_pkg::K_SR_OUT, 2'd0, 3);
        gate(lp_timing_pkg::K_NODLL, 2'd0, 3);
        gate(lp_timing_pkg::K_DLL, 2'd0, 6);
    endtask
    task automatic t_mpd_zq();
        apb(1'b1, lp_timing_pkg::OFS_XMPD, 32'h4);
        apb(1'b1, lp_timing_pkg::OFS_ZQ, 32'h6);
        one(lp_timing_pkg::K_MPD_IN, 2'd2, 16'h0);
        repeat (4) @(posedge pclk);
        #1 chk("mpd clock stopped", 32'h1, 32'(ckdis[2]));
        apb(1'b0, lp_timing_pkg::OFS_STAT, 32'h0);
        chk("status", 32'h0030004B, rd);
        one(lp_timing_pkg::K_CK_ON, 2'd2, 16'h0);
        gate(lp_timing_pkg::K_MPD_OUT, 2'd2, 3);
        gate(lp_timing_pkg::K_NODLL, 2'd2, 4);
        one(lp_timing_pkg::K_ZQCS, 2'd3, 16'h0);
        gate(lp_timing_pkg::K_NODLL, 2'd3, 6);
    endtask
    task automatic t_lat();
        int lat [3] = '{3, 10, 0};
        int cal [3] = '{2, 0, 10}; // second entry is the registered dimm setting
        int pl [3] = '{2, 3, 0};
        int cm [3] = '{12, 60, 12}; // completion covers the address delay
        logic [15:0] a [3] = '{16'hA5C3, 16'h1234, 16'h8001};
        int n;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, lp_timing_pkg::OFS_CMD, 32'((cal[i] << 8) | lat[i]));
            apb(1'b1, lp_timing_pkg::OFS_PAR, 32'((cm[i] << 8) | pl[i]));
            one(lp_timing_pkg::K_NODLL, 2'd1, a[i]);
            n = 0;
            do begin
                @(posedge pclk);
                #1 n++;
            end while (cmd_done[1] !== 1'b1 && n < 70);
            chk("completion delay", 32'(cm[i]), 32'(n));
            chk("address delay", 32'(lat[i] + cal[i]), 32'(adly));
            chk("address", 32'(a[i]), 32'(aseen));
            chk("parity", 32'(^a[i]), 32'(pseen[pl[i]]));
        end
    endtask
    // a legal request while the enable is low must not be taken
    task automatic t_freeze();
        @(posedge pclk);
        ce <= 1'b0;
        cmd_valid <= 1'b1;
        cmd_req <= '{kind: lp_timing_pkg::K_NODLL, rank: 2'd1, addr: 16'h0000};
        repeat (2) @(posedge pclk);
        #1 chk("frozen accept", 32'h0, 32'(cmd_accept));
        chk("frozen select", 32'hF, 32'(cs_n));
        @(posedge pclk);
        cmd_valid <= 1'b0;
        ce <= 1'b1;
    endtask
    // ==========
    // main sequence and watchdog
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cmd_valid = 1'b0;
        cmd_req = '0;
        n_errors = 0;
        checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        $display("test registers done");
        t_pd();
        $display("test power-down done");
        t_sr();
        $display("test self-refresh done");
        t_mpd_zq();
        $display("test max power-down and calibration done");
        t_lat();
        $display("test latencies done");
        t_freeze();
        $display("test clock enable done");
        close_out();
    end
    initial begin
        #100000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
